// File: inc/jrs_pkg.sv
// constants, packet words and segment sequences for the readback sequencer
// Functional notes
// - load eleven readback packet words, MSB first
// - packet bits with TMS low, last high
// - two TMS-high then two low to Shift-IR
// - output instruction LSB first, MSB exits
// - two TMS-high then two low to Shift-DR
// - clock readback bits, last with TMS high
// - Select-IR, Shift-IR, then three highs to Select-DR
// - direct mode reads with direct read instruction, then loads config-in
// - direct mode ends with CRC reset packets
// - compare unmasked bits, ignore mask-one bits
// - first mask bit aligns first readback bit
// - expected stream includes pad frame, masked only where mask bits say
// - host itself switches from write to read
// - packet words have fixed roles in order
package jrs_pkg;
  // link timing: host divides its own clock down to TCK
  localparam int SYS_PERIOD_NS = 50;
  localparam int TCK_PERIOD_NS = 400;
  localparam int TCK_HALF_CYC  = TCK_PERIOD_NS / (2 * SYS_PERIOD_NS);

  // instruction register codes, ten bits, LSB shifted first
  localparam int         IR_LEN     = 10;
  localparam logic [9:0] IR_CFG_IN  = 10'h3C5;
  localparam logic [9:0] IR_CFG_OUT = 10'h3C4;

  // segment lengths in packet words and in TCK cycles
  localparam int PKT_WORDS = 11;
  localparam int CRC_WORDS = 7;
  localparam int PKT_BITS  = PKT_WORDS * 32;
  localparam int CRC_BITS  = CRC_WORDS * 32;

  // fixed walks between tap states, in TCK cycles
  localparam int LEN_HI5 = 5;
  localparam int LEN_LO1 = 1;
  localparam int LEN_HI2 = 2;
  localparam int LEN_LO2 = 2;
  localparam int LEN_HI3 = 3;

  // readback packets: dummy, sync, noop, cmd hdr, read config, address hdr,
  // address zero, frame readout hdr, count hdr, two flush noops
  localparam logic [31:0] PKT_RB [0:PKT_WORDS-1] = '{
    32'hFFFF_FFFF, 32'hAA99_5566, 32'h2000_0000, 32'h3000_8001,
    32'h0000_0004, 32'h3000_2001, 32'h0000_0000, 32'h2800_6000,
    32'h4802_4090, 32'h2000_0000, 32'h2000_0000};

  // crc clean-up: dummy, sync, noop, cmd hdr, crc reset, two flush noops
  localparam logic [31:0] PKT_CRC [0:CRC_WORDS-1] = '{
    32'hFFFF_FFFF, 32'hAA99_5566, 32'h2000_0000, 32'h3000_8001,
    32'h0000_0007, 32'h2000_0000, 32'h2000_0000};

  typedef enum logic [3:0] {
    K_HI5, K_LO1, K_HI2, K_LO2, K_HI3, K_IR_IN, K_IR_OUT, K_IR_DIR,
    K_PKT, K_CRC, K_RB, K_END
  } jrs_seg_t;

  localparam int SEQ_LEN = 18;

  // standard flow through the configuration-input register
  localparam jrs_seg_t SEQ_STD [0:SEQ_LEN-1] = '{
    K_HI5, K_LO1, K_HI2, K_LO2, K_IR_IN, K_HI2, K_LO2, K_PKT, K_HI3,
    K_LO2, K_IR_OUT, K_HI2, K_LO2, K_RB, K_HI3, K_LO2, K_HI3, K_END};

  // direct read flow, followed by crc clean-up packets
  localparam jrs_seg_t SEQ_DIR [0:SEQ_LEN-1] = '{
    K_HI5, K_LO1, K_HI2, K_LO2, K_IR_DIR, K_HI2, K_LO2, K_RB, K_HI3,
    K_LO2, K_IR_IN, K_HI2, K_LO2, K_CRC, K_HI3, K_LO2, K_HI3, K_END};

  typedef enum logic {ST_IDLE, ST_RUN} jrs_state_t;
endpackage

// File: src/jrs_host.sv
// readback sequencer host: tap driver, verifier and readback word fifo
`timescale 1ns/1ns

module jrs_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0]    wptr;
  logic [AW-1:0]    rptr;
  logic [AW-1:0]    rptr_inc;
  logic [AW-1:0]    next_rptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;
  logic             head_bypass;

  // ready follows the count; valid and the head word come from flops so the
  // user sees clean pins, at the price of a small bypass path
  assign in_ready    = (count != (AW+1)'(DEPTH));
  assign push        = in_valid && in_ready;
  assign pop         = out_valid && out_ready;
  assign rptr_inc    = (rptr == AW'(DEPTH-1)) ? '0 : rptr + 1'b1;
  assign next_rptr   = pop ? rptr_inc : rptr;
  assign next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
  // a word pushed into the slot that becomes head is not in the array yet
  assign head_bypass = push && (wptr == next_rptr);

  // storage has no reset; only pointers and count carry control state
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr] <= in_data;
    end
  end

  // pointers wrap at depth, which need not be a power of two
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wptr <= (wptr == AW'(DEPTH-1)) ? '0 : wptr + 1'b1;
      end
      rptr  <= next_rptr;
      count <= next_count;
    end
  end

  // registered head: valid mirrors the next count, data the next head slot
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      out_valid <= (next_count != '0);
      out_data  <= head_bypass ? in_data : mem[next_rptr];
    end
  end
endmodule

module jrs_host #(
  parameter int         RB_BITS = 1024,
  parameter int         CW      = 20,
  parameter logic [9:0] IR_DIR  = 10'h3C2,
  parameter int         DEPTH   = 4
) (
  input  wire logic          SYS_CLK,
  input  wire logic          RST_B,
  input  wire logic          START,
  input  wire logic          MODE_DIRECT,
  output logic               TCK,
  output logic               TMS,
  output logic               TDI,
  input  wire logic          TDO,
  input  wire logic          EXP_VALID,
  input  wire logic          EXP_BIT,
  input  wire logic          MASK_BIT,
  output logic               EXP_READY,
  output logic        [31:0] RD_DATA,
  output logic               RD_VALID,
  input  wire logic          RD_READY,
  output logic               BUSY,
  output logic               DONE,
  output logic               PASS,
  output logic               MISMATCH,
  output logic      [CW-1:0] MISMATCH_POS
);
  localparam int DW = $clog2(jrs_pkg::TCK_HALF_CYC + 1);

  jrs_pkg::jrs_state_t state;
  jrs_pkg::jrs_seg_t   cur_kind;
  jrs_pkg::jrs_seg_t   nkind;
  logic [4:0]          seg;
  logic [4:0]          nseg;
  logic [CW-1:0]       bitc;
  logic [CW-1:0]       nbit;
  logic [CW-1:0]       rb_pos;
  logic [DW-1:0]       div;
  logic                mode;
  logic                last_bit;
  logic                tick;
  logic                stall;
  logic                cap_pend;
  logic                tdo_m;
  logic                tdo_s;
  logic [31:0]         word;
  logic                push;
  logic                fifo_ready;

  // segment kind for a step of the selected flow
  function automatic jrs_pkg::jrs_seg_t kind_of(input logic m, input logic [4:0] s);
    kind_of = m ? jrs_pkg::SEQ_DIR[s] : jrs_pkg::SEQ_STD[s];
  endfunction

  // length of a segment in TCK cycles
  function automatic logic [CW-1:0] len_of(input jrs_pkg::jrs_seg_t k);
    case (k)
      jrs_pkg::K_HI5:    len_of = CW'(jrs_pkg::LEN_HI5);
      jrs_pkg::K_LO1:    len_of = CW'(jrs_pkg::LEN_LO1);
      jrs_pkg::K_HI2:    len_of = CW'(jrs_pkg::LEN_HI2);
      jrs_pkg::K_LO2:    len_of = CW'(jrs_pkg::LEN_LO2);
      jrs_pkg::K_HI3:    len_of = CW'(jrs_pkg::LEN_HI3);
      jrs_pkg::K_IR_IN:  len_of = CW'(jrs_pkg::IR_LEN);
      jrs_pkg::K_IR_OUT: len_of = CW'(jrs_pkg::IR_LEN);
      jrs_pkg::K_IR_DIR: len_of = CW'(jrs_pkg::IR_LEN);
      jrs_pkg::K_PKT:    len_of = CW'(jrs_pkg::PKT_BITS);
      jrs_pkg::K_CRC:    len_of = CW'(jrs_pkg::CRC_BITS);
      jrs_pkg::K_RB:     len_of = CW'(RB_BITS);
      default:           len_of = CW'(1);
    endcase
  endfunction

  // tms per bit: shift segments raise it only on their final bit
  function automatic logic tms_of(input jrs_pkg::jrs_seg_t k, input logic [CW-1:0] b);
    case (k)
      jrs_pkg::K_HI5, jrs_pkg::K_HI2, jrs_pkg::K_HI3: tms_of = 1'b1;
      jrs_pkg::K_LO1, jrs_pkg::K_LO2:                 tms_of = 1'b0;
      jrs_pkg::K_IR_IN, jrs_pkg::K_IR_OUT, jrs_pkg::K_IR_DIR, jrs_pkg::K_PKT,
      jrs_pkg::K_CRC, jrs_pkg::K_RB: tms_of = (b == len_of(k) - 1'b1);
      default:                       tms_of = 1'b1;
    endcase
  endfunction

  // tdi per bit: instructions lsb first, packet words msb first
  function automatic logic tdi_of(input jrs_pkg::jrs_seg_t k, input logic [CW-1:0] b);
    case (k)
      jrs_pkg::K_IR_IN:  tdi_of = jrs_pkg::IR_CFG_IN[b[3:0]];
      jrs_pkg::K_IR_OUT: tdi_of = jrs_pkg::IR_CFG_OUT[b[3:0]];
      jrs_pkg::K_IR_DIR: tdi_of = IR_DIR[b[3:0]];
      jrs_pkg::K_PKT:    tdi_of = jrs_pkg::PKT_RB[b[8:5]][5'd31 - b[4:0]];
      jrs_pkg::K_CRC:    tdi_of = jrs_pkg::PKT_CRC[b[7:5]][5'd31 - b[4:0]];
      default:           tdi_of = 1'b0;
    endcase
  endfunction

  // where the walk goes after the current bit
  always_comb begin
    cur_kind = kind_of(mode, seg);
    last_bit = (bitc == len_of(cur_kind) - 1'b1);
    nseg     = last_bit ? seg + 1'b1 : seg;
    nbit     = last_bit ? '0 : bitc + 1'b1;
    nkind    = kind_of(mode, nseg);
  end

  // hold the clock while the verifier or the fifo cannot take a bit
  // stalling only in the high phase leaves tdo untouched, since the device
  // moves it on the fall; the cost is a stretched link period
  assign stall = TCK && cap_pend && !(EXP_VALID && fifo_ready);
  assign tick  = (div == DW'(jrs_pkg::TCK_HALF_CYC - 1)) && !stall;

  // two flops on the returning data; only the second is read
  // the first flop may go metastable, so no other logic may look at it
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      tdo_m <= 1'b0;
      tdo_s <= 1'b0;
    end else begin
      tdo_m <= TDO;
      tdo_s <= tdo_m;
    end
  end

  // half-period divider; TCK is made here, not sampled
  // it rests at zero in idle so the first rise always comes a full
  // half period after a start is taken
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      div <= '0;
    end else if (state == jrs_pkg::ST_IDLE || tick) begin
      div <= '0;
    end else if (!stall) begin
      div <= div + 1'b1;
    end
  end

  // sequencer: pins change on falling tck, device samples on rising tck
  // launching with the fall gives the device a whole half period of setup
  // before it samples, whatever the stall stretching does to the high phase
  // the host alone decides the write-to-read switch, no file marks it
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state <= jrs_pkg::ST_IDLE;
      mode  <= 1'b0;
      seg   <= '0;
      bitc  <= '0;
      TCK   <= 1'b0;
      TMS   <= 1'b1;
      TDI   <= 1'b0;
      BUSY  <= 1'b0;
      DONE  <= 1'b0;
    end else begin
      case (state)
        jrs_pkg::ST_IDLE: begin
          if (START) begin
            state <= jrs_pkg::ST_RUN;
            mode  <= MODE_DIRECT;
            seg   <= '0;
            bitc  <= '0;
            TMS   <= 1'b1;
            TDI   <= 1'b0;
            BUSY  <= 1'b1;
            DONE  <= 1'b0;
          end
        end
        jrs_pkg::ST_RUN: begin
          if (tick && !TCK) begin
            TCK <= 1'b1;
          end else if (tick) begin
            TCK <= 1'b0;
            if (nkind == jrs_pkg::K_END) begin
              state <= jrs_pkg::ST_IDLE;
              BUSY  <= 1'b0;
              DONE  <= 1'b1;
              TMS   <= 1'b1;
              TDI   <= 1'b0;
            end else begin
              seg  <= nseg;
              bitc <= nbit;
              TMS  <= tms_of(nkind, nbit);
              TDI  <= tdi_of(nkind, nbit);
            end
          end
        end
        default: begin
          state <= jrs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // a readback bit is marked at rising tck and taken at the next fall
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      cap_pend <= 1'b0;
      rb_pos   <= '0;
    end else if (state == jrs_pkg::ST_IDLE) begin
      cap_pend <= 1'b0;
      rb_pos   <= '0;
    end else if (tick && !TCK) begin
      cap_pend <= (cur_kind == jrs_pkg::K_RB);
    end else if (tick && cap_pend) begin
      cap_pend <= 1'b0;
      rb_pos   <= rb_pos + 1'b1;
    end
  end

  // pad frame comes first; the first mask bit meets the first data bit
  // only the first failure is kept, so the position points at the root
  // cause rather than at whatever follows it
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      MISMATCH     <= 1'b0;
      MISMATCH_POS <= '0;
      EXP_READY    <= 1'b0;
      PASS         <= 1'b0;
    end else begin
      EXP_READY <= tick && TCK && cap_pend;
      if (state == jrs_pkg::ST_IDLE && START) begin
        MISMATCH     <= 1'b0;
        MISMATCH_POS <= '0;
        PASS         <= 1'b0;
      end else if (tick && TCK && cap_pend) begin
        // mask one means don't care: user or null memory
        if (!MASK_BIT && (tdo_s != EXP_BIT) && !MISMATCH) begin
          MISMATCH     <= 1'b1;
          MISMATCH_POS <= rb_pos;
        end
      end else if (tick && TCK && nkind == jrs_pkg::K_END) begin
        PASS <= !MISMATCH;
      end
    end
  end

  // pack bits msb first; a short final word is pushed left aligned
  // push lands one cycle late; the fifo cannot fill meanwhile because
  // the next capture is at least one link period away
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      word <= '0;
      push <= 1'b0;
    end else begin
      push <= 1'b0;
      if (tick && TCK && cap_pend) begin
        word <= {word[30:0], tdo_s};
        push <= (rb_pos[4:0] == 5'd31) || (rb_pos == CW'(RB_BITS - 1));
        if (rb_pos == CW'(RB_BITS - 1) && rb_pos[4:0] != 5'd31) begin
          word <= {word[30:0], tdo_s} << (5'd31 - rb_pos[4:0]);
        end
      end
    end
  end

  // readback words toward the user; a stalled reader stalls tck
  jrs_fifo #(
    .WIDTH (32),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (SYS_CLK),
    .rst_b     (RST_B),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (word),
    .out_valid (RD_VALID),
    .out_ready (RD_READY),
    .out_data  (RD_DATA)
  );
endmodule

// File: testbench/jrs_host_props.sv
// port-level assertion checker for the readback sequencer host
`timescale 1ns/1ns
module jrs_host_props #(
  parameter int CW = 20
) (
  input wire logic          SYS_CLK,
  input wire logic          RST_B,
  input wire logic          START,
  input wire logic          TCK,
  input wire logic          TMS,
  input wire logic          TDI,
  input wire logic          EXP_VALID,
  input wire logic          EXP_READY,
  input wire logic [31:0]   RD_DATA,
  input wire logic          RD_VALID,
  input wire logic          RD_READY,
  input wire logic          BUSY,
  input wire logic          DONE,
  input wire logic          PASS,
  input wire logic          MISMATCH,
  input wire logic [CW-1:0] MISMATCH_POS
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  // a launch is a start taken while idle; at rest the link holds TMS high, TCK and TDI low
  sequence s_launch; START && !BUSY; endsequence
  sequence s_rest; TMS && !TCK && !TDI; endsequence
  a_tms_edge: assert property ($changed(TMS) |-> $fell(TCK))
    else $error("tms moved away from a falling link edge");
  a_tdi_edge: assert property ($changed(TDI) |-> $fell(TCK))
    else $error("tdi moved away from a falling link edge");
  a_high_phase: assert property ($rose(TCK) |-> TCK [*4])
    else $error("link clock high phase too short");
  a_low_phase: assert property ($rose(TCK) |-> !$past(TCK, 4))
    else $error("link clock low phase too short");
  a_launch_clear: assert property (s_launch |=> BUSY && !DONE && !PASS && !MISMATCH)
    else $error("launch did not clear the result flags");
  a_idle_rest: assert property (!BUSY |-> s_rest)
    else $error("link pins not at rest while idle");
  a_finish_reset: assert property ($rose(DONE) |-> ##[0:2] (!BUSY && TMS))
    else $error("sequence ended without tms high");
  a_pass_clean: assert property ($rose(PASS) |-> DONE && !MISMATCH)
    else $error("pass raised with a mismatch");
  a_mism_sticky: assert property (MISMATCH && !START |=> MISMATCH && $stable(MISMATCH_POS))
    else $error("mismatch flag or position lost");
  a_ready_cause: assert property (EXP_READY |-> !TCK && $past(EXP_VALID))
    else $error("expected bit consumed without a valid falling tick");
  a_ready_pulse: assert property (EXP_READY |=> !EXP_READY)
    else $error("expected bit consumed twice in a row");
  a_rd_hold: assert property (RD_VALID && !RD_READY |=> RD_VALID && $stable(RD_DATA))
    else $error("readback word changed before it was taken");
endmodule

bind jrs_host jrs_host_props #(.CW(CW)) u_props (.SYS_CLK(SYS_CLK), .RST_B(RST_B),
  .START(START), .TCK(TCK), .TMS(TMS), .TDI(TDI), .EXP_VALID(EXP_VALID),
  .EXP_READY(EXP_READY), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .RD_READY(RD_READY),
  .BUSY(BUSY), .DONE(DONE), .PASS(PASS), .MISMATCH(MISMATCH), .MISMATCH_POS(MISMATCH_POS));

// File: testbench/jrs_dev_model.sv
// behavioural device: tap controller, packet capture, readback stream
`timescale 1ns/1ns
module jrs_dev_model #(
  parameter int         RB_BITS = 150,
  parameter int         PAD     = 32,
  parameter logic [9:0] IR_DIR  = 10'h3C2
) (
  input  wire logic TCK,
  input  wire logic TMS,
  input  wire logic TDI,
  output logic      TDO = 1'b0
);
  // next tap state for tms low and tms high, indexed by state code
  localparam int N0 [16] = '{1, 1, 3, 4, 4, 6, 6, 4, 1, 10, 11, 11, 13, 13, 11, 1};
  localparam int N1 [16] = '{0, 2, 9, 5, 5, 8, 7, 8, 2, 0, 12, 12, 15, 14, 15, 2};
  int                 st = 0;
  int                 idx = 0;
  int                 nb = 0;
  logic [9:0]         ir = '0;
  logic [9:0]         ir_sh = '0;
  logic [31:0]        dr = '0;
  logic [0:RB_BITS-1] rb = '0;
  logic [0:RB_BITS-1] flip = '0;   // faults the bench commands on purpose
  logic [31:0]        words [$];
  logic [9:0]         irs [$];
  logic               armed = 1'b0;
  logic               crc_err = 1'b0;
  // pins sampled on the rising link edge
  always @(posedge TCK) begin
    if (st == 11)
      ir_sh = {TDI, ir_sh[9:1]};   // lsb first
    if (st == 3) begin
      nb = 0;
      idx = 0;
      if (ir == IR_DIR)
        crc_err = 1'b1;   // direct read leaves crc status dirty
    end
    if (st == 4 && ir == jrs_pkg::IR_CFG_IN) begin
      dr = {dr[30:0], TDI};   // msb first
      nb++;
      if (nb % 32 == 0) begin
        words.push_back(dr);
        if (dr == 32'h0000_0004)
          armed = 1'b1;   // read config command arms output
        if (dr == 32'h0000_0007)
          crc_err = 1'b0;   // crc reset command
      end
    end
    st = TMS ? N1[st] : N0[st];
    if (st == 0)
      armed = 1'b0;
    if (st == 15) begin
      ir = ir_sh;
      irs.push_back(ir);
    end
  end
  // data launched on the falling edge; outside a read shift only garbage
  always @(negedge TCK) begin
    if (st == 4 && idx < RB_BITS &&
        ((ir == jrs_pkg::IR_CFG_OUT && armed) || ir == IR_DIR)) begin
      TDO <= (idx < PAD ? 1'b0 : rb[idx]) ^ flip[idx];   // pad frame first
      idx++;
    end else
      TDO <= ~TDO;
  end
endmodule

// File: testbench/jrs_host_test.sv
// self-checking bench for the readback sequencer host
`timescale 1ns/1ns
module jrs_host_test;
  localparam int RB = 150;
  localparam int PAD = 32;
  localparam logic [31:0] PK [11] = '{32'hFFFF_FFFF, 32'hAA99_5566, 32'h2000_0000,
    32'h3000_8001, 32'h0000_0004, 32'h3000_2001, 32'h0000_0000, 32'h2800_6000,
    32'h4802_4090, 32'h2000_0000, 32'h2000_0000};
  localparam logic [31:0] CR [7] = '{32'hFFFF_FFFF, 32'hAA99_5566, 32'h2000_0000,
    32'h3000_8001, 32'h0000_0007, 32'h2000_0000, 32'h2000_0000};
  logic          sys_clk = 0, rst_b = 0, start = 0, mode = 0, ev = 0, eb = 0, mb = 0;
  logic          rr = 0, hold = 0, dn_q = 0;
  logic          tck, tms, tdi, tdo, er, rv, busy, done, pass, mism;
  logic [31:0]   rd;
  logic [19:0]   pos;
  logic [0:RB-1] msk;
  logic [31:0]   wq [$];
  logic [21:0]   rq [$];
  int            num_errors = 0;
  int            n_checks = 0;

  jrs_host #(.RB_BITS(RB)) dut (.SYS_CLK(sys_clk), .RST_B(rst_b), .START(start),
    .MODE_DIRECT(mode), .TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo), .EXP_VALID(ev),
    .EXP_BIT(eb), .MASK_BIT(mb), .EXP_READY(er), .RD_DATA(rd), .RD_VALID(rv),
    .RD_READY(rr), .BUSY(busy), .DONE(done), .PASS(pass), .MISMATCH(mism),
    .MISMATCH_POS(pos));
  jrs_dev_model #(.RB_BITS(RB), .PAD(PAD)) dev (.TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo));

  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // word sink stalls at random, or fully while the bench fills the fifo
  always @(posedge sys_clk) rr <= !hold && ($urandom % 3 != 0);

  // monitor: each taken word or finished run is matched to the oldest note
  always @(posedge sys_clk) begin
    if (rv && rr)
      check(rd, wq.pop_front());
    if (done && !dn_q)
      check({pass, mism, mism ? pos : 20'h0}, rq.pop_front());
    dn_q <= done;
  end

  // one readback run: two injected faults with chosen mask bits
  task automatic run(input logic md, input int e1, input int e2,
                     input logic m1, input logic m2, input logic fill);
    logic [31:0] wd;
    int          first;
    int          gap;
    dev.flip = '0;
    dev.flip[e1] = 1'b1;
    dev.flip[e2] = 1'b1;
    for (int k = 0; k < RB; k++) begin
      dev.rb[k] = 1'($urandom);
      msk[k] = ($urandom % 4 == 0);
    end
    msk[e1] = m1;
    msk[e2] = m2;
    first = !m1 ? e1 : (!m2 ? e2 : -1);
    for (int w = 0; w < (RB + 31) / 32; w++) begin
      for (int b = w * 32; b < w * 32 + 32; b++)
        wd = {wd[30:0], b < RB ? (b < PAD ? 1'b0 : dev.rb[b]) ^ dev.flip[b] : 1'b0};
      wq.push_back(wd);
    end
    rq.push_back({first < 0, first >= 0, first >= 0 ? 20'(first) : 20'h0});
    dev.irs.delete();
    dev.words.delete();
    hold <= fill;
    start <= 1'b1;
    mode <= md;
    @(posedge sys_clk);
    start <= 1'b0;
    fork
      begin   // a start while busy must change nothing
        repeat (200) @(posedge sys_clk);
        start <= 1'b1;
        @(posedge sys_clk);
        start <= 1'b0;
      end
      if (fill) begin
        repeat (7000) @(posedge sys_clk);
        check({rv, tck}, 2'b11);
        hold <= 1'b0;
      end
      for (int k = 0; k < RB; k++) begin
        gap = $urandom % 3;
        if (gap > 0) begin
          ev <= 1'b0;
          repeat (gap) @(posedge sys_clk);
        end
        ev <= 1'b1;
        eb <= k < PAD ? 1'b0 : dev.rb[k];   // pad frame is part of the expected stream
        mb <= msk[k];
        @(posedge sys_clk);
        while (er !== 1'b1) @(posedge sys_clk);
      end
    join
    ev <= 1'b0;
    while (done !== 1'b1) @(posedge sys_clk);
    repeat (40) @(posedge sys_clk);
    // the closing shift-ir visit passes update-ir once more
    check(dev.irs.size(), 3);
    check(dev.irs[0], md ? 10'h3C2 : jrs_pkg::IR_CFG_IN);
    check(dev.irs[1], md ? jrs_pkg::IR_CFG_IN : jrs_pkg::IR_CFG_OUT);
    check(dev.words.size(), md ? 7 : 11);
    for (int i = 0; i < dev.words.size(); i++)
      check(dev.words[i], md ? CR[i % 7] : PK[i % 11]);
    // three highs out of shift-ir stop in select-dr (state code 2)
    check(dev.st, 2);
    check(dev.crc_err, 1'b0);
    check(wq.size(), 0);
  endtask

  initial begin
    void'($urandom(5876));
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    run(1'b0, 40, RB - 1, 1'b1, 1'b1, 1'b1);   // masked faults only, fifo filled
    run(1'b1, 33, 100, 1'b0, 1'b0, 1'b0);   // direct read, first fault recorded
    run(1'b0, 0, RB - 1, 1'b0, 1'b1, 1'b0);   // fault on the very first bit
    final_report();
  end

  // watchdog: three runs need about 15000 cycles including the fifo hold
  initial begin
    repeat (80000) @(posedge sys_clk);
    num_errors++;
    final_report();
  end
endmodule
